// ===== hw/line_threshold_pkg.sv
// constants and types shared by the threshold interrupt logic
// assumes one 100 MHz system clock and an 8-bit register port
// Operation
// R1 - flag bit 3 shows threshold crossed
// R2 - pin interrupt when flag, mask, enable set
// R3 - flag stays set until written zero
// R4 - bit 2 selects current or voltage
// R5 - mask bit 1 gates pin interrupt
// R6 - polarity 0 triggers below threshold
// R7 - polarity 1 triggers above threshold
// R8 - 8-bit threshold shared by both sources
// R9 - compare on each selected measurement update
package line_threshold_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [7:0] THRESHOLD_OFFSET = 8'h2b;
    localparam logic [7:0] CONTROL_OFFSET   = 8'h2c;
    localparam logic [7:0] GLOBAL_OFFSET    = 8'h60;
    localparam logic [7:0] STATUS_OFFSET    = 8'h61;
    localparam logic [7:0] MASK_OFFSET      = 8'h62;

    // control register field positions
    localparam int FLAG_BIT     = 3;
    localparam int SOURCE_BIT   = 2;
    localparam int MASK_BIT     = 1;
    localparam int POLARITY_BIT = 0;

    // global register field position
    localparam int GLOBAL_IRQ_EN_BIT = 0;

    // interrupt status bits
    localparam int NUM_EVENTS    = 2;
    localparam int EV_CROSS_BIT  = 0;
    localparam int EV_UPDATE_BIT = 1;

    // values after reset
    localparam logic [7:0] THRESHOLD_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET   = 8'h00;
    localparam logic [7:0] GLOBAL_RESET    = 8'h00;
    localparam logic [1:0] STATUS_RESET    = 2'h0;
    localparam logic [1:0] MASK_RESET      = 2'h0;

    typedef struct packed {
        logic threshold_crossed_flag;
        logic measure_source_select;
        logic threshold_irq_mask;
        logic threshold_polarity;
    } control_t;

    typedef struct packed {
        logic [7:0] value;
        logic       update;
    } reading_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

endpackage : line_threshold_pkg

// ===== hw/threshold_compare.sv
// magnitude comparator for one signed measurement against a threshold
// assumes reading and its update strobe come from clk_sys logic
`timescale 1ns/10ps
module threshold_compare
    import line_threshold_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire reading_t   sample,
    input  wire logic [7:0] threshold_value,
    input  wire logic       threshold_polarity,
    output logic            trigger
);

    // magnitude of a two's complement byte; -128 saturates to 127
    function automatic logic [7:0] magnitude(input logic [7:0] v);
        logic [7:0] neg;
        neg = 8'h00 - v;
        if (!v[7]) begin
            magnitude = v;
        end else if (v == 8'h80) begin
            magnitude = 8'h7f;
        end else begin
            magnitude = neg;
        end
    endfunction : magnitude

    logic [7:0] mag;
    logic       hit;

    always_comb begin
        mag = magnitude(sample.value);
        if (threshold_polarity) begin
            hit = mag > threshold_value; // R7
        end else begin
            hit = mag < threshold_value; // R6
        end
    end

    // one pulse per qualifying update
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            trigger <= 1'b0;
        end else begin
            trigger <= sample.update & hit; // R9
        end
    end

endmodule : threshold_compare

// ===== hw/sticky_status.sv
// sticky event bits cleared by a read; a set in the clearing cycle wins
// assumes set pulses and the read strobe are on clk_sys
`timescale 1ns/10ps
module sticky_status
    import line_threshold_pkg::*;
#(
    parameter int WIDTH = 2
) (
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] set_pulse,
    input  wire logic             read_clear,
    output logic      [WIDTH-1:0] status
);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            status <= '0;
        end else if (read_clear) begin
            status <= set_pulse;
        end else begin
            status <= status | set_pulse;
        end
    end

endmodule : sticky_status

// ===== hw/line_threshold_interrupt.sv
// threshold interrupt control: registers, source select and pin interrupt
// assumes readings come from same-clock logic with a one-cycle update
// strobe, and a register port with read data one cycle after the strobe
`timescale 1ns/10ps
module line_threshold_interrupt
    import line_threshold_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic [7:0]        loop_current_reading,
    input  wire logic              loop_current_update,
    input  wire logic [7:0]        line_voltage_reading,
    input  wire logic              line_voltage_update,
    output logic                   analog_out_irq_pin,
    output logic                   irq
);

    reg_req_t   req;
    reading_t   selected;
    control_t   control_reg;
    logic [7:0] threshold_value_reg;
    logic       global_irq_enable_reg;
    logic [NUM_EVENTS-1:0] mask_reg;
    logic [NUM_EVENTS-1:0] status;
    logic [NUM_EVENTS-1:0] events;
    logic [7:0] rdata_next;
    logic       trigger;
    logic       wr_threshold;
    logic       wr_control;
    logic       wr_global;
    logic       wr_mask;
    logic       rd_status;

    assign req = '{addr: reg_addr, wdata: reg_wdata,
                   wr: reg_wr, rd: reg_rd};

    assign wr_threshold = req.wr && req.addr == THRESHOLD_OFFSET;
    assign wr_control   = req.wr && req.addr == CONTROL_OFFSET;
    assign wr_global    = req.wr && req.addr == GLOBAL_OFFSET;
    assign wr_mask      = req.wr && req.addr == MASK_OFFSET;
    assign rd_status    = req.rd && req.addr == STATUS_OFFSET;

    // only the chosen source's updates count; the other is ignored
    always_comb begin
        if (control_reg.measure_source_select) begin // R4
            selected.value  = line_voltage_reading;
            selected.update = line_voltage_update;
        end else begin
            selected.value  = loop_current_reading;
            selected.update = loop_current_update;
        end
    end

    threshold_compare u_compare (
        .clk_sys            (clk_sys),
        .rstn               (rstn),
        .sample             (selected),
        .threshold_value    (threshold_value_reg), // R8
        .threshold_polarity (control_reg.threshold_polarity),
        .trigger            (trigger)
    );

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            threshold_value_reg <= THRESHOLD_RESET;
        end else if (wr_threshold) begin
            threshold_value_reg <= req.wdata; // R8
        end
    end

    // one process owns the whole control word so it has a single driver;
    // writing 1 leaves the flag alone; a trigger beats a clearing write
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            control_reg.threshold_crossed_flag <= CONTROL_RESET[FLAG_BIT];
            control_reg.measure_source_select  <= CONTROL_RESET[SOURCE_BIT];
            control_reg.threshold_irq_mask     <= CONTROL_RESET[MASK_BIT];
            control_reg.threshold_polarity     <= CONTROL_RESET[POLARITY_BIT];
        end else begin
            if (wr_control) begin
                control_reg.measure_source_select <= req.wdata[SOURCE_BIT];
                control_reg.threshold_irq_mask    <= req.wdata[MASK_BIT];
                control_reg.threshold_polarity    <= req.wdata[POLARITY_BIT];
            end
            if (trigger) begin
                control_reg.threshold_crossed_flag <= 1'b1; // R1
            end else if (wr_control && !req.wdata[FLAG_BIT]) begin
                control_reg.threshold_crossed_flag <= 1'b0; // R3
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            global_irq_enable_reg <= GLOBAL_RESET[GLOBAL_IRQ_EN_BIT];
        end else if (wr_global) begin
            global_irq_enable_reg <= req.wdata[GLOBAL_IRQ_EN_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mask_reg <= MASK_RESET;
        end else if (wr_mask) begin
            mask_reg <= req.wdata[NUM_EVENTS-1:0];
        end
    end

    always_comb begin
        events = '0;
        events[EV_CROSS_BIT]  = trigger;
        events[EV_UPDATE_BIT] = selected.update;
    end

    sticky_status #(
        .WIDTH (NUM_EVENTS)
    ) u_status (
        .clk_sys    (clk_sys),
        .rstn       (rstn),
        .set_pulse  (events),
        .read_clear (rd_status),
        .status     (status)
    );

    // pin driven from flops so it never glitches toward the host
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            analog_out_irq_pin <= 1'b0;
            irq                <= 1'b0;
        end else begin
            analog_out_irq_pin <= control_reg.threshold_crossed_flag
                                  && control_reg.threshold_irq_mask // R5
                                  && global_irq_enable_reg; // R2
            irq                <= |(status & mask_reg);
        end
    end

    // unmapped and reserved bits read zero
    always_comb begin
        rdata_next = 8'h00;
        unique case (req.addr)
            THRESHOLD_OFFSET: begin
                rdata_next = threshold_value_reg;
            end
            CONTROL_OFFSET: begin
                rdata_next[FLAG_BIT]     = control_reg.threshold_crossed_flag;
                rdata_next[SOURCE_BIT]   = control_reg.measure_source_select;
                rdata_next[MASK_BIT]     = control_reg.threshold_irq_mask;
                rdata_next[POLARITY_BIT] = control_reg.threshold_polarity;
            end
            GLOBAL_OFFSET: begin
                rdata_next[GLOBAL_IRQ_EN_BIT] = global_irq_enable_reg;
            end
            STATUS_OFFSET: begin
                rdata_next[NUM_EVENTS-1:0] = status;
            end
            MASK_OFFSET: begin
                rdata_next[NUM_EVENTS-1:0] = mask_reg;
            end
            default: begin
                rdata_next = 8'h00;
            end
        endcase
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (req.rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule : line_threshold_interrupt

// ===== verif/line_threshold_interrupt_asserts.sv
// checker for the threshold interrupt block, bound to its top ports
// assumes register port and readings are clk_sys synchronous
`timescale 1ns/10ps
module line_threshold_interrupt_asserts
    import line_threshold_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic [7:0]  loop_current_reading,
    input wire logic        loop_current_update,
    input wire logic [7:0]  line_voltage_reading,
    input wire logic        line_voltage_update,
    input wire logic        analog_out_irq_pin,
    input wire logic        irq
);
    logic [7:0] thr_reg, v, m;
    logic [2:0] ctl_reg;
    logic       gen_reg, hit, any;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            thr_reg <= 8'h00;
            ctl_reg <= 3'h0;
            gen_reg <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == THRESHOLD_OFFSET) thr_reg <= reg_wdata;
            if (reg_addr == CONTROL_OFFSET) ctl_reg <= reg_wdata[2:0];
            if (reg_addr == GLOBAL_OFFSET) gen_reg <= reg_wdata[0];
        end
    end
    // -128 has no positive twin, so it counts as 127
    assign v = ctl_reg[2] ? line_voltage_reading : loop_current_reading;
    assign m = (v == 8'h80) ? 8'h7f : (v[7] ? 8'h00 - v : v);
    assign any = loop_current_update | line_voltage_update;
    assign hit = (ctl_reg[2] ? line_voltage_update : loop_current_update)
                 && (ctl_reg[0] ? m > thr_reg : m < thr_reg);
    property p_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    a_idle: assert property (p_idle)
        else $error("read data not zero outside read slot");
    property p_ctl; $past(reg_rd && reg_addr == CONTROL_OFFSET) |->
        reg_rdata[7:4] == 4'h0 && reg_rdata[2:0] == $past(ctl_reg);
    endproperty
    a_ctl: assert property (p_ctl)
        else $error("control readback wrong");
    property p_thr; $past(reg_rd && reg_addr == THRESHOLD_OFFSET) |->
        reg_rdata == $past(thr_reg); endproperty
    a_thr: assert property (p_thr)
        else $error("threshold readback wrong");
    property p_hit; hit && ctl_reg[1] && gen_reg && !reg_wr ##1 !reg_wr
        |-> ##2 analog_out_irq_pin; endproperty
    a_hit: assert property (p_hit)
        else $error("crossing did not raise pin");
    property p_mask; reg_wr && reg_addr == CONTROL_OFFSET && !reg_wdata[1]
        |-> ##2 !analog_out_irq_pin; endproperty
    a_mask: assert property (p_mask)
        else $error("pin high after mask cleared");
    property p_gen; reg_wr && reg_addr == GLOBAL_OFFSET && !reg_wdata[0]
        |-> ##2 !analog_out_irq_pin; endproperty
    a_gen: assert property (p_gen)
        else $error("pin high after global enable cleared");
    property p_gate; !(ctl_reg[1] && gen_reg) |=> !analog_out_irq_pin;
    endproperty
    a_gate: assert property (p_gate)
        else $error("pin high while gated");
    property p_clr; reg_rd && reg_addr == STATUS_OFFSET && !any
        && !$past(any) |-> ##2 !irq; endproperty
    a_clr: assert property (p_clr)
        else $error("irq stayed after status read");
endmodule : line_threshold_interrupt_asserts
bind line_threshold_interrupt line_threshold_interrupt_asserts i_chk (
    .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .loop_current_reading(loop_current_reading),
    .loop_current_update(loop_current_update),
    .line_voltage_reading(line_voltage_reading),
    .line_voltage_update(line_voltage_update),
    .analog_out_irq_pin(analog_out_irq_pin), .irq(irq));

// ===== verif/host_irq_model.sv
// host model: counts interrupt requests arriving on the pin
// assumes an active-high registered level on clk_sys
`timescale 1ns/10ps
module host_irq_model (
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       analog_out_irq_pin,
    output logic      [7:0] irq_seen
);
    logic pin_reg;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pin_reg  <= 1'b0;
            irq_seen <= 8'h00;
        end else begin
            pin_reg <= analog_out_irq_pin;
            if (analog_out_irq_pin && !pin_reg) irq_seen <= irq_seen + 8'h01;
        end
    end
endmodule : host_irq_model

// ===== verif/line_threshold_interrupt_bench.sv
// self-checking bench: register tasks, random readings, pin and irq checks
// assumes the checker is bound in and the host model watches the pin
`timescale 1ns/10ps
module line_threshold_interrupt_bench
    import line_threshold_pkg::*;
();
    logic       clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
    logic       lcu = 1'b0, lvu = 1'b0, pin, irq, f, s, g, sel;
    logic [7:0] addr = 8'h00, wd = 8'h00, lc = 8'h00, lv = 8'h00;
    logic [7:0] rdata, seen, thr, ctl, va, vb, d;
    logic [1:0] u, mk;
    logic [7:0] ra [6] = '{THRESHOLD_OFFSET, CONTROL_OFFSET, GLOBAL_OFFSET,
                           STATUS_OFFSET, MASK_OFFSET, 8'h00};
    int         seed = 32'h7eab, fail_count = 0, comparisons = 0, rises = 0;
    always #5 clk = ~clk;
    line_threshold_interrupt i_dut (.clk_sys(clk), .rstn(rstn),
        .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata(rdata), .loop_current_reading(lc),
        .loop_current_update(lcu), .line_voltage_reading(lv),
        .line_voltage_update(lvu), .analog_out_irq_pin(pin), .irq(irq));
    host_irq_model i_host (.clk_sys(clk), .rstn(rstn),
        .analog_out_irq_pin(pin), .irq_seen(seen));
    task check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task wreg(input logic [7:0] a, input logic [7:0] dv);
        @(posedge clk);
        addr <= a;
        wd <= dv;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    task rreg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rreg
    task upd(input logic [7:0] a, input logic [7:0] b, input logic [1:0] e);
        @(posedge clk);
        lc <= a;
        lv <= b;
        {lvu, lcu} <= e;
        @(posedge clk);
        {lvu, lcu} <= 2'h0;
    endtask : upd
    function automatic logic meets(input logic [7:0] v, input logic [7:0] t,
                                   input logic pl);
        logic [7:0] m;
        m = (v == 8'h80) ? 8'h7f : (v[7] ? 8'h00 - v : v);
        return pl ? m > t : m < t;
    endfunction : meets
    task print_verdict;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #200000;
        fail_count++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        wreg(8'h00, 8'hff);
        foreach (ra[i]) begin
            rreg(ra[i]);
            check(d, 8'h00);
        end
        wreg(CONTROL_OFFSET, 8'hff);
        rreg(CONTROL_OFFSET);
        check(d, 8'h07);
        wreg(MASK_OFFSET, 8'h01);
        for (int i = 0; i < 30; i++) begin
            thr = 8'($random(seed));
            ctl = {5'h00, 3'($random(seed))};
            g = 1'($random(seed));
            mk = 2'($random(seed));
            wreg(THRESHOLD_OFFSET, thr);
            wreg(GLOBAL_OFFSET, {7'h00, g});
            wreg(MASK_OFFSET, {6'h00, mk});
            wreg(CONTROL_OFFSET, ctl);
            {f, s} = 2'h0;
            repeat (2) begin
                {va, vb, u} = 18'($random(seed));
                if (i % 4 == 0) {va, vb} = {thr, thr};
                if (i % 4 == 1) {va, vb, thr} = 24'h80807f;
                if (i % 4 == 1) wreg(THRESHOLD_OFFSET, thr);
                upd(va, vb, u);
                sel = ctl[2] ? u[1] : u[0];
                f |= sel && meets(ctl[2] ? vb : va, thr, ctl[0]);
                s |= sel;
            end
            repeat (4) @(posedge clk);
            #1 check({7'h00, pin}, {7'h00, f & ctl[1] & g});
            check({7'h00, irq}, {7'h00, |({s, f} & mk)});
            rreg(CONTROL_OFFSET);
            check(d, {4'h0, f, ctl[2:0]});
            rises += int'(f & ctl[1] & g);
            wreg(CONTROL_OFFSET, ctl);
            rreg(STATUS_OFFSET);
            check(d, {6'h00, s, f});
            rreg(CONTROL_OFFSET);
            check(d, {5'h00, ctl[2:0]});
            rreg(MASK_OFFSET);
            check(d, {6'h00, mk});
            rreg(GLOBAL_OFFSET);
            check(d, {7'h00, g});
        end
        check(seen, 8'(rises));
        // trigger and clearing write meet in one cycle: the set must win
        wreg(THRESHOLD_OFFSET, 8'h00);
        wreg(CONTROL_OFFSET, 8'h01);
        @(posedge clk);
        lc <= 8'h05;
        lcu <= 1'b1;
        @(posedge clk);
        lcu <= 1'b0;
        addr <= CONTROL_OFFSET;
        wd <= 8'h01;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rreg(CONTROL_OFFSET);
        check(d, 8'h09);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rreg(CONTROL_OFFSET);
        check(d, 8'h00);
        print_verdict();
    end
endmodule : line_threshold_interrupt_bench
